// ### shared/conv_ctrl_pkg.sv
// Package with register map, field layouts, reset values and timing constants.
package conv_ctrl_pkg;

	// Register byte addresses.
	localparam logic [11:0] CFG_ADDR    = 12'h000;
	localparam logic [11:0] RATE_ADDR   = 12'h004;
	localparam logic [11:0] CTRL_ADDR   = 12'h008;
	localparam logic [11:0] STATUS_ADDR = 12'h00c;
	localparam logic [11:0] RESULT_ADDR = 12'h010;

	// Configuration and control register field positions.
	localparam int GAIN_LSB     = 0;
	localparam int BYPASS_BIT   = 3;
	localparam int MUX_LSB      = 4;
	localparam int VREF_LSB     = 8;
	localparam int TURBO_BIT    = 10;
	localparam int CTRL_START   = 0;
	localparam int CTRL_PDOWN   = 1;

	// Reset values and the internal reference code.
	localparam logic [2:0] GAIN_RST  = 3'h0;
	localparam logic [3:0] MUX_RST   = 4'h0;
	localparam logic [1:0] VREF_RST  = 2'h0;
	localparam logic [1:0] VREF_INT  = 2'h0;
	localparam logic [15:0] RATE_RST = 16'h0100;

	// Gain codes and forced-bypass mux range.
	localparam logic [2:0] GAIN_CODE_4 = 3'h2;
	localparam logic [3:0] MUX_SE_LO   = 4'h8;
	localparam logic [3:0] MUX_SE_HI   = 4'hb;

	// Clock rates and derived cycle counts.
	localparam int PCLK_KHZ      = 250000;
	localparam int OSC_NORM_KHZ  = 1024;
	localparam int OSC_TURBO_KHZ = 2048;
	localparam int MOD_DIV       = 4;
	localparam int REF_SETTLE_US = 25;
	localparam int REF_SETTLE_CYC = (REF_SETTLE_US * PCLK_KHZ + 999) / 1000;
	// Phase added per pclk cycle, as a 0.32 fraction of one oscillator period.
	// The tick spacing jitters by one pclk cycle, and the truncated step leaves the average rate slightly low.
	localparam logic [31:0] NORM_STEP  = 32'((64'(OSC_NORM_KHZ) << 32) / PCLK_KHZ);
	localparam logic [31:0] TURBO_STEP = 32'((64'(OSC_TURBO_KHZ) << 32) / PCLK_KHZ);

endpackage : conv_ctrl_pkg

// ### core/conv_ctrl.sv
// Gain, bypass, reference and modulator clock control for the converter core.
`timescale 1ns/1ps

module conv_ctrl #(
	parameter int REF_SETTLE = conv_ctrl_pkg::REF_SETTLE_CYC
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	output logic             amp_enable,
	output logic [2:0]       amp_gain_code,
	output logic [2:0]       cap_gain_code,
	output logic [3:0]       input_select_field,
	output logic [1:0]       vref_select,
	output logic             osc_tick,
	output logic             modulator_clock,
	output logic             conv_done
);

	logic [2:0]  gain_q;
	logic        amp_bypass_bit_q;
	logic [3:0]  mux_q;
	logic [1:0]  vref_q;
	logic        turbo_q;
	logic        pdown_q;
	logic [15:0] rate_q;
	logic        busy_q;
	logic        start_q;
	logic [15:0] result_q;
	logic        done_sticky_q;
	logic [31:0] phase_q;
	logic [1:0]  mod_cnt_q;
	logic [15:0] dec_cnt_q;
	logic [31:0] acc_q;
	logic [31:0] settle_q;
	logic [31:0] prdata_d;

	// Access decode; every access takes exactly one wait state.
	wire access   = psel && penable;
	wire wr       = access && pwrite && pstrb[0];
	wire hit_cfg  = paddr == conv_ctrl_pkg::CFG_ADDR;
	wire hit_rate = paddr == conv_ctrl_pkg::RATE_ADDR;
	wire hit_ctrl = paddr == conv_ctrl_pkg::CTRL_ADDR;
	wire hit_stat = paddr == conv_ctrl_pkg::STATUS_ADDR;
	wire hit_res  = paddr == conv_ctrl_pkg::RESULT_ADDR;
	wire mapped   = hit_cfg || hit_rate || hit_ctrl || hit_stat || hit_res;

	// Bypass and gain resolution; forced bypass clamps the gain code.
	wire forced_bypass = (mux_q >= conv_ctrl_pkg::MUX_SE_LO) &&
	                     (mux_q <= conv_ctrl_pkg::MUX_SE_HI);
	wire low_gain      = gain_q <= conv_ctrl_pkg::GAIN_CODE_4;
	wire bypass        = forced_bypass || (amp_bypass_bit_q && low_gain);
	wire [2:0] eff_gain = (forced_bypass && !low_gain) ? conv_ctrl_pkg::GAIN_CODE_4 : gain_q;
	// Above gain 4 the capacitor stage stays at 4 and the amplifier supplies the rest.
	wire [2:0] amp_code = low_gain ? 3'h0 : 3'(eff_gain - conv_ctrl_pkg::GAIN_CODE_4);
	wire [2:0] cap_code = low_gain ? eff_gain : conv_ctrl_pkg::GAIN_CODE_4;

	// Oscillator tick from a phase accumulator; step follows the mode bit.
	wire [31:0] step  = turbo_q ? conv_ctrl_pkg::TURBO_STEP : conv_ctrl_pkg::NORM_STEP;
	wire [32:0] phsum = {1'b0, phase_q} + {1'b0, step};
	wire        tick  = phsum[32];
	wire        ref_ready = (settle_q == 32'h0);
	wire        mod_edge  = tick && (mod_cnt_q == 2'h3);
	wire        last_bit  = mod_edge && (dec_cnt_q == 16'h1);

	// Read mux for the register file.
	assign prdata_d = hit_cfg  ? {21'h0, turbo_q, vref_q, mux_q, amp_bypass_bit_q, gain_q} :
	                  hit_rate ? {16'h0, rate_q} :
	                  hit_ctrl ? {30'h0, pdown_q, 1'b0} :
	                  hit_stat ? {28'h0, bypass, ref_ready, busy_q, done_sticky_q} :
	                  hit_res  ? {16'h0, result_q} : 32'h0;

	// Bus answer, registered so pready stands for the single access cycle.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0;
		end else begin
			pready  <= access && !pready;
			pslverr <= access && !pready && !mapped;
			prdata  <= (access && !pready && !pwrite) ? prdata_d : 32'h0;
		end
	end

	// Configuration fields; writes take effect on the completing edge.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			gain_q           <= conv_ctrl_pkg::GAIN_RST;
			amp_bypass_bit_q <= 1'b0;
			mux_q            <= conv_ctrl_pkg::MUX_RST;
			vref_q           <= conv_ctrl_pkg::VREF_RST;
			turbo_q          <= 1'b0;
			rate_q           <= conv_ctrl_pkg::RATE_RST;
			pdown_q          <= 1'b0;
		end else if (wr && pready) begin
			if (hit_cfg) begin
				gain_q           <= pwdata[conv_ctrl_pkg::GAIN_LSB +: 3];
				amp_bypass_bit_q <= pwdata[conv_ctrl_pkg::BYPASS_BIT];
				mux_q            <= pwdata[conv_ctrl_pkg::MUX_LSB +: 4];
				vref_q           <= pwdata[conv_ctrl_pkg::VREF_LSB +: 2];
				turbo_q          <= pwdata[conv_ctrl_pkg::TURBO_BIT];
			end
			if (hit_rate && pwdata[15:0] != 16'h0)
				rate_q <= pwdata[15:0];
			if (hit_ctrl)
				pdown_q <= pwdata[conv_ctrl_pkg::CTRL_PDOWN];
		end
	end

	// Events decoded on the completing edge of a write.
	wire start_req = wr && pready && hit_ctrl && pwdata[conv_ctrl_pkg::CTRL_START];
	wire to_int    = wr && pready && hit_cfg &&
	                 pwdata[conv_ctrl_pkg::VREF_LSB +: 2] == conv_ctrl_pkg::VREF_INT &&
	                 vref_q != conv_ctrl_pkg::VREF_INT;
	wire pd_exit   = wr && pready && hit_ctrl && pdown_q && !pwdata[conv_ctrl_pkg::CTRL_PDOWN];

	// Reference settling timer, restarted on power-down exit or switch to internal.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			settle_q <= 32'(REF_SETTLE);
		else if (to_int || pd_exit)
			settle_q <= 32'(REF_SETTLE);
		else if (settle_q != 32'h0)
			settle_q <= settle_q - 32'h1;
	end

	// Oscillator phase and divide-by-four modulator counter.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			phase_q   <= 32'h0;
			mod_cnt_q <= 2'h0;
			osc_tick  <= 1'b0;
			modulator_clock <= 1'b0;
		end else begin
			phase_q  <= phsum[31:0];
			osc_tick <= tick;
			if (tick)
				mod_cnt_q <= mod_cnt_q + 2'h1;
			modulator_clock <= mod_cnt_q[1];
		end
	end

	// Conversion: start waits for the reference, then runs until the rate_q-th modulator edge.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			start_q       <= 1'b0;
			busy_q        <= 1'b0;
			dec_cnt_q     <= 16'h0;
			acc_q         <= 32'h0;
			result_q      <= 16'h0;
			conv_done     <= 1'b0;
			done_sticky_q <= 1'b0;
		end else begin
			conv_done <= last_bit && busy_q;
			if (start_req && !pdown_q)
				start_q <= 1'b1;
			if (start_q && ref_ready && !busy_q) begin
				start_q   <= 1'b0;
				busy_q    <= 1'b1;
				dec_cnt_q <= rate_q;
				acc_q     <= 32'h0;
			end else if (busy_q && mod_edge) begin
				acc_q     <= acc_q + {29'h0, eff_gain};
				dec_cnt_q <= dec_cnt_q - 16'h1;
				if (last_bit) begin
					busy_q   <= 1'b0;
					result_q <= acc_q[15:0];
				end
			end
			// Completion wins over a read-clear in the same cycle.
			if (busy_q && last_bit)
				done_sticky_q <= 1'b1;
			else if (access && !pready && !pwrite && hit_stat)
				done_sticky_q <= 1'b0;
		end
	end

	// Analog control outputs, registered.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			amp_enable         <= 1'b1;
			amp_gain_code      <= 3'h0;
			cap_gain_code      <= 3'h0;
			input_select_field <= conv_ctrl_pkg::MUX_RST;
			vref_select        <= conv_ctrl_pkg::VREF_RST;
		end else begin
			amp_enable         <= !bypass && !pdown_q;
			amp_gain_code      <= amp_code;
			cap_gain_code      <= cap_code;
			input_select_field <= mux_q;
			vref_select        <= vref_q;
		end
	end

	// Forced bypass must disable the amplifier on the next edge.
	property p_forced_bypass;
		@(posedge pclk) disable iff (!presetn) forced_bypass |=> !amp_enable;
	endproperty
	a_forced_bypass: assert property (p_forced_bypass) else $error("Amp on under forced mux");

	property p_bit_bypass;
		@(posedge pclk) disable iff (!presetn) (amp_bypass_bit_q && gain_q <= 3'h2) |=> !amp_enable;
	endproperty
	a_bit_bypass: assert property (p_bit_bypass) else $error("Amp on with bypass bit");

	property p_clamp;
		@(posedge pclk) disable iff (!presetn)
			(forced_bypass && gain_q > 3'h2) |=> (cap_gain_code == 3'h2 && amp_gain_code == 3'h0);
	endproperty
	a_clamp: assert property (p_clamp) else $error("Gain not clamped to four");

	property p_high_gain;
		@(posedge pclk) disable iff (!presetn)
			(!forced_bypass && gain_q > 3'h2) |=> (cap_gain_code == 3'h2 && amp_gain_code != 3'h0);
	endproperty
	a_high_gain: assert property (p_high_gain) else $error("High gain split wrong");

	property p_mod_div;
		@(posedge pclk) disable iff (!presetn) (tick && mod_cnt_q == 2'h1) |=> mod_cnt_q == 2'h2;
	endproperty
	a_mod_div: assert property (p_mod_div) else $error("Modulator divider skipped");

	property p_settle;
		@(posedge pclk) disable iff (!presetn) (to_int || pd_exit) |=> !ref_ready;
	endproperty
	a_settle: assert property (p_settle) else $error("Reference ready too early");

	property p_no_start;
		@(posedge pclk) disable iff (!presetn) (!ref_ready && !busy_q) |=> !busy_q;
	endproperty
	a_no_start: assert property (p_no_start) else $error("Started before settle");

	property p_done;
		@(posedge pclk) disable iff (!presetn) (busy_q && last_bit) |=> (conv_done && !busy_q);
	endproperty
	a_done: assert property (p_done) else $error("Conversion end not flagged");

	property p_vref;
		@(posedge pclk) disable iff (!presetn) $rose(presetn) |-> vref_q == 2'h0;
	endproperty
	a_vref: assert property (p_vref) else $error("Reference reset not internal");

endmodule : conv_ctrl

// ### tb/adc_gain_ref_clock_control_test.sv
// Self-checking testbench for the gain, reference and modulator clock control block.
`timescale 1ns/1ps

module adc_gain_ref_clock_control_test;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h00000000;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        amp_enable;
	logic [2:0]  amp_gain_code;
	logic [2:0]  cap_gain_code;
	logic [3:0]  input_select_field;
	logic [1:0]  vref_select;
	logic        osc_tick;
	logic        modulator_clock;
	logic        conv_done;
	logic        mod_prev = 1'b0;
	integer      mismatches = 0;
	integer      samples_checked = 0;
	integer      seed = 32'hc17a26db;
	integer      ticks = 0;
	integer      mod_rises = 0;
	logic [31:0] rd;
	logic        er;
	logic [10:0] cfg;

	// A short settle count keeps the reference wait small in simulation.
	conv_ctrl #(.REF_SETTLE(20)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .amp_enable(amp_enable),
		.amp_gain_code(amp_gain_code), .cap_gain_code(cap_gain_code),
		.input_select_field(input_select_field), .vref_select(vref_select),
		.osc_tick(osc_tick), .modulator_clock(modulator_clock), .conv_done(conv_done));

	// The clock toggles every half period of 2 ns.
	always #2 pclk = ~pclk;

	// Oscillator ticks and modulator clock rises are counted for rate checks.
	always @(posedge pclk) begin
		mod_prev <= modulator_clock;
		if (osc_tick === 1'b1) ticks <= ticks + 1;
		if (modulator_clock === 1'b1 && mod_prev === 1'b0) mod_rises <= mod_rises + 1;
	end

	// Every comparison is counted; a mismatch is reported at once.
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			mismatches++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	// Measured counts may differ from the ideal by the phase of the oscillator.
	task automatic near(input integer got, input integer exp, input integer tol);
		chk(32'((got > exp - tol) && (got < exp + tol)), 32'h1);
	endtask : near

	// One APB transfer; the request is held until pready is sampled high.
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		integer n;
		n = 0;
		@(posedge pclk);
		psel    <= 1'b1;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		penable <= 1'b0;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) chk(32'h0, 32'h1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	// Expected {amplifier on, amplifier gain code, capacitor gain code}.
	function automatic logic [6:0] exp_amp(input logic [10:0] c);
		logic [2:0] g;
		logic       f;
		logic       byp;
		g = c[2:0];
		f = (c[7:4] >= 4'h8) && (c[7:4] <= 4'hb);
		if (f && g > 3'h2) g = 3'h2;
		byp = f || (c[3] && g <= 3'h2);
		return {~byp, (g > 3'h2) ? g - 3'h2 : 3'h0, (g > 3'h2) ? 3'h2 : g};
	endfunction : exp_amp

	// Ideal pclk cycles for a conversion of the given modulator periods.
	function automatic integer exp_conv(input integer rate, input logic turbo);
		return rate * 4 * 250000 / (turbo ? 2048 : 1024);
	endfunction : exp_conv

	// Runs a conversion and returns the cycles from start to completion.
	task automatic convert(input logic turbo, output integer n);
		apb(1'b1, 12'h000, {21'h0, turbo, 10'h000});
		apb(1'b1, 12'h004, 32'h00000002);
		// Start just after a modulator period begins, so the first period counts in full.
		do @(posedge pclk); while (!(mod_prev === 1'b1 && modulator_clock === 1'b0));
		apb(1'b1, 12'h008, 32'h00000001);
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (conv_done !== 1'b1 && n < 9000);
	endtask : convert

	task automatic end_of_test;
		$display("checked %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : end_of_test

	// The watchdog cuts a hang well beyond the expected run of some 25000 cycles.
	initial begin
		#240000;
		mismatches++;
		end_of_test();
	end

	// Main sequence: reset values, errors, gain and bypass table, clock rates, conversions, status.
	initial begin
		integer n;
		integer t0;
		integer m0;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		chk({amp_enable, vref_select}, 32'h4);
		apb(1'b0, 12'h000, 32'h0);
		chk(rd, 32'h0);
		apb(1'b0, 12'h004, 32'h0);
		chk(rd, 32'h100);
		apb(1'b0, 12'h020, 32'h0);
		chk({31'h0, er}, 32'h1);
		chk(rd, 32'h0);
		$display("reset and map test done");
		for (int i = 0; i < 84; i++) begin
			if (i < 64) cfg = {1'b0, 2'(i), 4'({4'h8, 4'hb, 4'hc, 4'h7} >> (4 * (i % 4))),
				1'(i / 32), 3'(i / 4)};
			else cfg = 11'($random(seed));
			apb(1'b1, 12'h000, {21'h0, cfg});
			repeat (2) @(posedge pclk);
			chk({amp_enable, amp_gain_code, cap_gain_code}, exp_amp(cfg));
			chk({input_select_field, vref_select}, {cfg[7:4], cfg[9:8]});
			apb(1'b0, 12'h000, 32'h0);
			chk(rd, {21'h0, cfg});
		end
		$display("gain and bypass test done");
		for (int m = 0; m < 2; m++) begin
			apb(1'b1, 12'h000, {21'h0, 1'(m), 10'h000});
			repeat (10) @(posedge pclk);
			t0 = ticks;
			m0 = mod_rises;
			repeat (10000) @(posedge pclk);
			near(ticks - t0, 41 * (m + 1), 3);
			near(mod_rises - m0, 10 * (m + 1), 3);
		end
		$display("clock rate test done");
		convert(1'b0, n);
		near(n, exp_conv(2, 1'b0), 300);
		convert(1'b1, n);
		near(n, exp_conv(2, 1'b1), 300);
		$display("conversion test done");
		// Done is sticky until read; a zero rate and a start in power-down are refused.
		apb(1'b0, 12'h00c, 32'h0);
		chk(rd, 32'h5);
		apb(1'b0, 12'h00c, 32'h0);
		chk(rd, 32'h4);
		apb(1'b1, 12'h004, 32'h0);
		apb(1'b0, 12'h004, 32'h0);
		chk(rd, 32'h2);
		apb(1'b1, 12'h008, 32'h2);
		repeat (2) @(posedge pclk);
		chk({31'h0, amp_enable}, 32'h0);
		apb(1'b1, 12'h008, 32'h3);
		apb(1'b1, 12'h008, 32'h0);
		apb(1'b0, 12'h00c, 32'h0);
		chk(rd, 32'h0);
		repeat (30) @(posedge pclk);
		apb(1'b0, 12'h00c, 32'h0);
		chk(rd, 32'h4);
		$display("status and power-down test done");
		end_of_test();
	end
endmodule : adc_gain_ref_clock_control_test
